// File: src/iprio_regs.sv
/*
 * Interrupt priority registers: sixteen per-source priority fields and
 * a read-only level/vector status word, on an AXI4-Lite slave port.
 * Assumes one clock, synchronous active-low reset, a CPU that compares
 * the offered level with its own and pulses irq_accept on entry, and
 * trap requests that always carry a level of eight or more.
 */
`timescale 1ns/10ps
`include "iprio_defs.svh"

// Behaviour
// RULE1 - field value ranks source, seven highest
// RULE2 - zero priority disables source request
// RULE3 - fields read/write, reset to binary 100
// RULE4 - unimplemented bits ignore writes, read zero
// RULE5 - status bits 11:8 show new level
// RULE6 - status bits 6:0 show pending vector
// RULE7 - status read-only, resets to zero
// RULE8 - every source owns an independent field
// RULE9 - all sources start at level four
// RULE10 - traps at levels 8-15 never masked
// RULE11 - status updates on each accepted interrupt
module iprio_regs (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // register bus
   input  wire logic [7:0]            awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   input  wire logic [7:0]            araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   // interrupt sources, see source order below
   input  wire logic [15:0]           src_req,
   input  wire logic                  trap_req,
   input  wire iprio_pkg::iprio_level_t trap_level,
   input  wire iprio_pkg::iprio_vec_t trap_vector,
   // cpu core
   input  wire iprio_pkg::iprio_level_t cpu_level,
   input  wire logic                  irq_accept,
   output logic                       irq_req,
   output iprio_pkg::iprio_level_t    irq_level,
   output iprio_pkg::iprio_vec_t      irq_vector,
   output iprio_pkg::iprio_level_t    new_cpu_level,
   output iprio_pkg::iprio_vec_t      pending_vector_number
);

   // source order: 0 pwm special event, 1 serial error, 2..5 pwm
   // generators 1..4, 6..8 comparators 2..4, 9..15 adc pairs 0..6
   localparam logic [7:0] FOFS [16] = '{
      `IPRIO_OFS_PSE,   `IPRIO_OFS_SER,
      `IPRIO_OFS_PWM12, `IPRIO_OFS_PWM12,
      `IPRIO_OFS_PWM34, `IPRIO_OFS_PWM34,
      `IPRIO_OFS_CMP2,  `IPRIO_OFS_CMP34, `IPRIO_OFS_CMP34,
      `IPRIO_OFS_ADC01, `IPRIO_OFS_ADC01,
      `IPRIO_OFS_ADC25, `IPRIO_OFS_ADC25,
      `IPRIO_OFS_ADC25, `IPRIO_OFS_ADC25,
      `IPRIO_OFS_ADC6
   };
   localparam int FLSB [16] = '{
      `IPRIO_LSB_PSE,  `IPRIO_LSB_SER,
      `IPRIO_LSB_PWM1, `IPRIO_LSB_PWM2,
      `IPRIO_LSB_PWM3, `IPRIO_LSB_PWM4,
      `IPRIO_LSB_CMP2, `IPRIO_LSB_CMP3, `IPRIO_LSB_CMP4,
      `IPRIO_LSB_ADC0, `IPRIO_LSB_ADC1,
      `IPRIO_LSB_ADC2, `IPRIO_LSB_ADC3,
      `IPRIO_LSB_ADC4, `IPRIO_LSB_ADC5,
      `IPRIO_LSB_ADC6
   };

   // write channel holding registers
   logic                         aw_held;
   logic [7:0]                   w_addr;
   logic                         w_held;
   logic [31:0]                  w_data;
   logic [3:0]                   w_strb;
   logic                         do_write;
   logic                         wr_mapped;
   logic                         rd_take;
   logic                         rd_mapped;
   logic [31:0]                  rd_word;

   // priority fields and their write strobes
   iprio_pkg::iprio_prio_vec_t   prio_q;
   logic [15:0]                  fwe;
   logic [15:0]                  wr_hit;
   logic [15:0]                  rd_hit;

   // arbitration results
   logic                         best_valid;
   iprio_pkg::iprio_level_t      best_level;
   iprio_pkg::iprio_idx_t        best_idx;
   iprio_pkg::iprio_vec_t        best_vec;
   logic                         user_present;
   logic                         next_irq_req;
   iprio_pkg::iprio_level_t      next_irq_level;
   iprio_pkg::iprio_vec_t        next_irq_vector;
   logic                         irq_taken;
   logic                         wr_stat;
   logic                         rd_stat;

   // ---- bus: write side ----

   // each channel is accepted on its own; the write fires once both are
   // held and no response is still waiting, so one write at a time
   assign awready  = !aw_held;
   assign wready   = !w_held;
   assign do_write = aw_held && w_held && !bvalid;

   // address and data captured independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_addr  <= 8'h00;
      end else if (awvalid && awready) begin
         aw_held <= 1'b1;
         w_addr  <= awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (wvalid && wready) begin
         w_held <= 1'b1;
         w_data <= wdata;
         w_strb <= wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // per-field write decode; a field lives in a single byte lane, and
   // bits outside every field have no storage at all
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_field
         assign wr_hit[gi] = (w_addr == FOFS[gi]);
         assign rd_hit[gi] = (araddr == FOFS[gi]);
         assign fwe[gi] = do_write && wr_hit[gi]
                          && w_strb[FLSB[gi] / 8]; // RULE4
         iprio_field u_field (
            .aclk    (aclk),
            .aresetn (aresetn),
            .we      (fwe[gi]),
            .wdata   (w_data[FLSB[gi] +: 3]),
            .prio    (prio_q[gi])
         ); // RULE8
      end
   endgenerate

   // status word is mapped but takes no write
   assign wr_stat   = (w_addr == `IPRIO_OFS_STAT);
   assign wr_mapped = (|wr_hit) || wr_stat; // RULE7

   // response follows the write by one cycle, held until bready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= `IPRIO_RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp  <= wr_mapped ? `IPRIO_RESP_OKAY : `IPRIO_RESP_DECERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ---- bus: read side ----

   // a new read is taken only once the previous data has gone
   assign arready   = !rvalid;
   assign rd_take   = arvalid && arready;
   assign rd_stat   = (araddr == `IPRIO_OFS_STAT);
   assign rd_mapped = (|rd_hit) || rd_stat;

   // read word assembled from fields; every other bit stays zero
   always_comb begin
      rd_word = 32'h0000_0000;
      for (int i = 0; i < 16; i++) begin
         if (rd_hit[i]) begin
            rd_word = rd_word | (32'(prio_q[i]) << FLSB[i]); // RULE4
         end
      end
      if (rd_stat) begin
         rd_word = 32'(new_cpu_level) << `IPRIO_STAT_LVL_LSB // RULE5
                   | 32'(pending_vector_number); // RULE6
      end
   end

   // read data registered at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `IPRIO_RESP_OKAY;
      end else if (rd_take) begin
         rvalid <= 1'b1;
         rdata  <= rd_word;
         rresp  <= rd_mapped ? `IPRIO_RESP_OKAY : `IPRIO_RESP_DECERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ---- request selection ----

   iprio_arb u_arb (
      .req        (src_req),
      .prio       (prio_q),
      .best_valid (best_valid),
      .best_level (best_level),
      .best_idx   (best_idx),
      .best_vec   (best_vec)
   );

   // a user request is offered only above the current cpu level;
   // traps bypass both the priority fields and that comparison
   assign user_present    = best_valid && (best_level > cpu_level);
   assign next_irq_req    = trap_req || user_present; // RULE10
   assign next_irq_level  = trap_req ? trap_level : best_level;
   assign next_irq_vector = trap_req ? trap_vector : best_vec;

   // offer registered, so a source change shows one cycle later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_req    <= 1'b0;
         irq_level  <= 4'h0;
         irq_vector <= 7'h00;
      end else begin
         irq_req    <= next_irq_req; // RULE1 RULE2
         irq_level  <= next_irq_level;
         irq_vector <= next_irq_vector;
      end
   end

   // ---- status word ----

   // latched only when the cpu takes the offer; software cannot touch
   // it, so a stale value stays visible until the next entry
   assign irq_taken = irq_accept && irq_req;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         new_cpu_level         <= 4'h0; // RULE7
         pending_vector_number <= 7'h00;
      end else if (irq_taken) begin
         new_cpu_level         <= irq_level; // RULE5 RULE11
         pending_vector_number <= irq_vector; // RULE6 RULE11
      end
   end

   // ---- checks ----

   a_status_latch: assert property (@(posedge aclk) // RULE11
      disable iff (!aresetn)
      irq_taken |=> new_cpu_level == $past(irq_level)
                    && pending_vector_number == $past(irq_vector))
      else $error("status word did not take the accepted request");

   a_status_readonly: assert property (@(posedge aclk) // RULE7
      disable iff (!aresetn)
      do_write && wr_stat && !irq_taken
      |=> $stable(new_cpu_level) && $stable(pending_vector_number))
      else $error("status word changed on a software write");

   a_trap_unmasked: assert property (@(posedge aclk) // RULE10
      disable iff (!aresetn)
      trap_req |=> irq_req && irq_level == $past(trap_level)
                   && irq_vector == $past(trap_vector))
      else $error("trap request was not offered");

   a_disabled_source: assert property (@(posedge aclk) // RULE2
      disable iff (!aresetn)
      best_valid |-> prio_q[best_idx] != `IPRIO_PRIO_OFF
                     && src_req[best_idx])
      else $error("disabled or idle source selected");

   a_user_rank: assert property (@(posedge aclk) // RULE1
      disable iff (!aresetn)
      !trap_req && best_valid
      |-> ##1 irq_req == ($past(best_level) > $past(cpu_level))
              && (!irq_req || irq_level == $past(best_level)))
      else $error("user request offered at wrong level");

   // status reads are left out here: a trap level sets bit 11 there
   a_unused_zero: assert property (@(posedge aclk) // RULE4
      disable iff (!aresetn)
      rd_take && !rd_stat
      |=> rdata[31:15] == 17'h00000 && rdata[11] == 1'b0
          && rdata[7] == 1'b0 && rdata[3] == 1'b0)
      else $error("unimplemented bits read nonzero");

   a_status_read: assert property (@(posedge aclk) // RULE6
      disable iff (!aresetn)
      rd_take && rd_stat
      |=> rdata[11:8] == $past(new_cpu_level)
          && rdata[6:0] == $past(pending_vector_number)
          && rdata[31:12] == 20'h00000 && rdata[7] == 1'b0)
      else $error("status read returned wrong fields");

   a_write_answer: assert property (@(posedge aclk) // RULE4
      disable iff (!aresetn)
      do_write |=> bvalid && bresp == ($past(wr_mapped)
                   ? `IPRIO_RESP_OKAY : `IPRIO_RESP_DECERR))
      else $error("write not answered next cycle");

   a_read_answer: assert property (@(posedge aclk) // RULE4
      disable iff (!aresetn)
      rd_take |=> rvalid && rresp == ($past(rd_mapped)
                  ? `IPRIO_RESP_OKAY : `IPRIO_RESP_DECERR))
      else $error("read not answered next cycle");

   a_unmapped_write: assert property (@(posedge aclk) // RULE4
      disable iff (!aresetn)
      do_write && !wr_mapped |=> $stable(prio_q))
      else $error("write to an unmapped address changed a field");

   a_idle_no_offer: assert property (@(posedge aclk) // RULE2
      disable iff (!aresetn)
      !trap_req && !best_valid |=> !irq_req)
      else $error("offer made with no enabled request");

   a_status_hold: assert property (@(posedge aclk) // RULE7
      disable iff (!aresetn)
      !irq_taken
      |=> $stable(new_cpu_level) && $stable(pending_vector_number))
      else $error("status word changed without an accepted entry");

endmodule // iprio_regs

// File: src/iprio_defs.svh
/*
 * Register offsets, field positions, reset values and bus answer codes
 * of the interrupt priority register block.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef IPRIO_DEFS_SVH
`define IPRIO_DEFS_SVH

// byte addresses, one aligned word per register
`define IPRIO_OFS_PSE    8'h00
`define IPRIO_OFS_SER    8'h04
`define IPRIO_OFS_PWM12  8'h08
`define IPRIO_OFS_PWM34  8'h0c
`define IPRIO_OFS_CMP2   8'h10
`define IPRIO_OFS_CMP34  8'h14
`define IPRIO_OFS_ADC01  8'h18
`define IPRIO_OFS_ADC25  8'h1c
`define IPRIO_OFS_ADC6   8'h20
`define IPRIO_OFS_STAT   8'h24

// lowest bit of each three-bit priority field inside its register
`define IPRIO_LSB_PSE    4
`define IPRIO_LSB_SER    4
`define IPRIO_LSB_PWM1   8
`define IPRIO_LSB_PWM2   12
`define IPRIO_LSB_PWM3   0
`define IPRIO_LSB_PWM4   4
`define IPRIO_LSB_CMP2   12
`define IPRIO_LSB_CMP3   0
`define IPRIO_LSB_CMP4   4
`define IPRIO_LSB_ADC0   8
`define IPRIO_LSB_ADC1   12
`define IPRIO_LSB_ADC2   0
`define IPRIO_LSB_ADC3   4
`define IPRIO_LSB_ADC4   8
`define IPRIO_LSB_ADC5   12
`define IPRIO_LSB_ADC6   0

// status register layout, reset values, vector base, bus answers
`define IPRIO_STAT_LVL_LSB 8
`define IPRIO_PRIO_RST     3'h4
`define IPRIO_PRIO_OFF     3'h0
`define IPRIO_VEC_BASE     7'h10
`define IPRIO_RESP_OKAY    2'h0
`define IPRIO_RESP_DECERR  2'h3

`endif

// File: src/iprio_pkg.sv
/*
 * Types shared by the interrupt priority register block.
 * Assumes nothing of its surroundings.
 */
package iprio_pkg;
   typedef logic [2:0]        iprio_prio_t;
   typedef logic [3:0]        iprio_level_t;
   typedef logic [6:0]        iprio_vec_t;
   typedef logic [3:0]        iprio_idx_t;
   typedef logic [15:0][2:0]  iprio_prio_vec_t;
endpackage

// File: src/iprio_field.sv
/*
 * One three-bit priority field, loaded by a qualified write strobe.
 * Assumes the caller has already decoded address and byte lane.
 */
`timescale 1ns/10ps
`include "iprio_defs.svh"

module iprio_field (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                we,
   input  wire iprio_pkg::iprio_prio_t wdata,
   output iprio_pkg::iprio_prio_t   prio
);

   // reset loads level four: top bit set, lower bits clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prio <= `IPRIO_PRIO_RST; // RULE3 RULE9
      end else if (we) begin
         prio <= wdata; // RULE3 RULE8
      end
   end

   a_field_write: assert property (@(posedge aclk) disable iff (!aresetn)
      we |=> prio == $past(wdata)) // RULE3
      else $error("priority field missed a write");

   a_field_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> prio == `IPRIO_PRIO_RST) // RULE9
      else $error("priority field not at level four after reset");

endmodule // iprio_field

// File: src/iprio_arb.sv
/*
 * Picks the highest-ranked enabled request among the sixteen sources.
 * Assumes requests and priorities are stable within the clock cycle.
 */
`timescale 1ns/10ps
`include "iprio_defs.svh"

module iprio_arb (
   input  wire logic [15:0]             req,
   input  wire iprio_pkg::iprio_prio_vec_t prio,
   output logic                         best_valid,
   output iprio_pkg::iprio_level_t      best_level,
   output iprio_pkg::iprio_idx_t        best_idx,
   output iprio_pkg::iprio_vec_t        best_vec
);

   // strict compare: on equal rank the lower source index wins
   always_comb begin
      best_valid = 1'b0;
      best_level = 4'h0;
      best_idx   = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (req[i] && prio[i] != `IPRIO_PRIO_OFF // RULE2
             && {1'b0, prio[i]} > best_level) begin // RULE1
            best_valid = 1'b1;
            best_level = {1'b0, prio[i]};
            best_idx   = 4'(i);
         end
      end
   end

   // vector numbers run upward from a fixed base in source order
   assign best_vec = `IPRIO_VEC_BASE + {3'h0, best_idx};

endmodule // iprio_arb

// File: tb/iprio_cpu_model.sv
/*
 * Behavioural cpu core: takes offers of the priority block, moves to the offered level.
 * Assumes the offer ports of iprio_regs and a tb that sets the idle level.
 */
`timescale 1ns/10ps

module iprio_cpu_model (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic                    accept_en,
   input  wire iprio_pkg::iprio_level_t level_set,
   input  wire logic                    irq_req,
   input  wire iprio_pkg::iprio_level_t irq_level,
   output logic                         irq_accept,
   output iprio_pkg::iprio_level_t      cpu_level
);
   // one-cycle accept pulse with a gap, so a stale offer may be refused
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_accept <= 1'b0;
         cpu_level  <= 4'h0;
      end else begin
         irq_accept <= accept_en & irq_req & ~irq_accept;
         if (!accept_en)
            cpu_level <= level_set;
         else if (irq_accept & irq_req)
            cpu_level <= irq_level; // entry sets the cpu level to the offered level
      end
   end
endmodule // iprio_cpu_model

// File: tb/tb_top.sv
/*
 * Self-checking bench of iprio_regs: AXI4-Lite register traffic, offers
 * to a cpu model and status capture, with lfsr stimulus.
 * Assumes the design package, header and the cpu model are compiled first.
 */
`timescale 1ns/10ps
`include "iprio_defs.svh"

module tb_top;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
   logic        bready, arvalid, arready, rvalid, rready;
   logic        trap_req, irq_accept, irq_req, accept_en, ex_v;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, trap_level, cpu_level, irq_level, level_set;
   logic [3:0]  new_cpu_level, ex_lvl;
   logic [1:0]  bresp, rresp;
   logic [15:0] src_req, lfsr, r, st_exp;
   logic [6:0]  trap_vector, irq_vector, pending_vector_number, ex_vec;
   logic [15:0] shadow [0:8];
   int          mismatches, tests_run, i, n;
   // implemented bits per register; source to register and field lsb
   localparam logic [8:0][15:0] MASK = {16'h0007, 16'h7777, 16'h7700,
      16'h0077, 16'h7000, 16'h0077, 16'h7700, 16'h0070, 16'h0070};
   localparam logic [15:0][3:0] SRC_REG = 64'h8777_7665_5433_2210;
   localparam logic [15:0][3:0] SRC_LSB = 64'h0c84_0c84_0c40_c844;

   iprio_regs iprio_regs_inst (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .src_req(src_req), .trap_req(trap_req),
      .trap_level(trap_level), .trap_vector(trap_vector),
      .cpu_level(cpu_level), .irq_accept(irq_accept), .irq_req(irq_req),
      .irq_level(irq_level), .irq_vector(irq_vector),
      .new_cpu_level(new_cpu_level),
      .pending_vector_number(pending_vector_number));

   iprio_cpu_model iprio_cpu_model_inst (.aclk(aclk), .aresetn(aresetn),
      .accept_en(accept_en), .level_set(level_set), .irq_req(irq_req),
      .irq_level(irq_level), .irq_accept(irq_accept), .cpu_level(cpu_level));

   // clock at 100 MHz
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   function automatic logic [2:0] prio_of(input int s);
      return shadow[SRC_REG[s]][SRC_LSB[s] +: 3];
   endfunction

   task automatic chk(input string what, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // one AXI4-Lite transfer; handshakes judged at the falling edge before
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] rd, output logic [1:0] rs);
      logic av, wv, ha, hw, done;
      int k;
      @(posedge aclk);
      if (wr) begin
         awaddr <= a; wdata <= d; wstrb <= s;
         awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      end else begin
         araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      end
      av = 1'b1; wv = wr; done = 1'b0;
      for (k = 0; k < 40 && !done; k++) begin
         @(negedge aclk);
         ha = wr ? awready : arready;
         hw = wready;
         done = wr ? bvalid : rvalid;
         rs = wr ? bresp : rresp;
         rd = rdata;
         @(posedge aclk);
         if (av && ha) begin
            av = 1'b0;
            if (wr) awvalid <= 1'b0;
            else arvalid <= 1'b0;
         end
         if (wv && hw) begin
            wv = 1'b0;
            wvalid <= 1'b0;
         end
         if (done) begin
            bready <= 1'b0;
            rready <= 1'b0;
         end
      end
      if (done !== 1'b1) begin
         mismatches++;
         end_sim();
      end
   endtask

   // access register slot x (9 status, 10 and up unmapped) and check it
   task automatic access(input logic wr, input logic [5:0] x,
      input logic [31:0] d, input logic [3:0] s);
      logic [31:0] rd, ed;
      logic [1:0] rs;
      logic [15:0] m;
      bus(wr, {x, 2'b00}, d, s, rd, rs);
      chk("resp", rs, x < 10 ? `IPRIO_RESP_OKAY : `IPRIO_RESP_DECERR);
      if (wr && x < 9) begin
         m = MASK[x] & {{8{s[1]}}, {8{s[0]}}};
         shadow[x] = (shadow[x] & ~m) | (d[15:0] & m);
      end
      ed = x < 9 ? {16'h0, shadow[x]} : x == 9 ? {16'h0, st_exp} : 32'h0;
      if (!wr) chk("rdata", rd, ed);
   endtask

   // drive requests, let the model settle its level, check the offer
   task automatic offer(input logic [15:0] rq, input logic tr,
      input logic [3:0] tl, input logic [6:0] tv, input logic [3:0] cl);
      int s;
      @(posedge aclk);
      src_req <= rq; trap_req <= tr; trap_level <= tl;
      trap_vector <= tv; level_set <= cl;
      ex_lvl = 4'h0; ex_vec = 7'h0;
      for (s = 0; s < 16; s++)
         if (rq[s] && {1'b0, prio_of(s)} > ex_lvl) begin
            ex_lvl = {1'b0, prio_of(s)};
            ex_vec = `IPRIO_VEC_BASE + 7'(s);
         end
      ex_v = tr | (ex_lvl > cl);
      if (tr) begin
         ex_lvl = tl;
         ex_vec = tv;
      end
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk("irq_req", irq_req, ex_v);
      if (ex_v) chk("irq_level", irq_level, ex_lvl);
      if (ex_v) chk("irq_vector", irq_vector, ex_vec);
   endtask

   // let the cpu model take the offer, then check the status word
   task automatic take();
      @(posedge aclk);
      accept_en <= 1'b1;
      for (n = 0; n < 10 && !irq_accept; n++) @(negedge aclk);
      if (irq_accept !== 1'b1) begin
         mismatches++;
         end_sim();
      end
      repeat (2) @(posedge aclk);
      accept_en <= 1'b0;
      st_exp = {4'h0, ex_lvl, 1'b0, ex_vec};
      @(negedge aclk);
      chk("level", new_cpu_level, ex_lvl);
      chk("vector", pending_vector_number, ex_vec);
      access(1'b0, 6'd9, 32'h0, 4'h0);
   endtask

   initial begin
      {awvalid, wvalid, bready, arvalid, rready, trap_req} = 6'h0;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      {src_req, trap_level, trap_vector, level_set} = 31'h0;
      {accept_en, aresetn} = 2'h0;
      lfsr = 16'h002b;
      st_exp = 16'h0;
      mismatches = 0;
      tests_run = 0;
      for (i = 0; i < 9; i++) shadow[i] = MASK[i] & 16'h4444;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values, then all ones and all zeros everywhere
      for (i = 0; i < 11; i++) access(1'b0, 6'(i), 32'h0, 4'h0);
      offer(16'hffff, 1'b0, 4'h0, 7'h0, 4'h3);
      for (i = 0; i < 11; i++) access(1'b1, 6'(i), 32'hffffffff, 4'hf);
      for (i = 0; i < 11; i++) access(1'b0, 6'(i), 32'h0, 4'h0);
      offer(16'hffff, 1'b0, 4'h0, 7'h0, 4'h6);
      take();
      for (i = 0; i < 11; i++) access(1'b1, 6'(i), 32'h0, 4'hf);
      offer(16'hffff, 1'b0, 4'h0, 7'h0, 4'h0);
      offer(16'hffff, 1'b1, 4'h8, 7'h05, 4'hf);
      take();
      // random traffic and requests
      for (i = 0; i < 80; i++) begin
         r = rnd();
         access(1'b1, 6'(r[3:0] % 11), {rnd(), rnd()}, r[7:4]);
         access(1'b0, 6'(r[3:0] % 11), 32'h0, 4'h0);
         r = rnd();
         offer(rnd(), r[0] & r[1], {1'b1, r[4:2]}, r[11:5],
            {1'b0, r[14:12]});
         if (ex_v) take();
      end
      end_sim();
   end
endmodule // tb_top
